// ### design/cfh_pkg.sv
// Shared constants and types for the configuration status handshake
package cfh_pkg;

    // Clock and timing
    localparam int CFH_CLK_PERIOD_NS = 20;
    localparam int CFH_TIMER_W = 16;
    localparam int CFH_POR_TIME_NS_DEF = 100000;
    localparam int CFH_INIT_CYCLES_DEF = 64;

    // Pin levels
    localparam logic CFH_PIN_LOW = 1'h0;
    localparam logic CFH_DRIVE = 1'h1;
    localparam logic CFH_RELEASE = 1'h0;
    localparam logic CFH_SELECT_OFF_N = 1'h1;
    localparam logic CFH_SELECT_ON_N = 1'h0;

    // Controller states
    typedef enum {
        CFH_ST_POR_ARM,
        CFH_ST_POR_WAIT,
        CFH_ST_RELOAD,
        CFH_ST_IDLE,
        CFH_ST_LOAD,
        CFH_ST_RELEASE,
        CFH_ST_INIT,
        CFH_ST_USER,
        CFH_ST_ERROR
    } cfh_state_e;

    // Events from the configuration data path
    typedef struct packed {
        logic image_done;
        logic error;
    } cfh_data_s;

    // One open-drain or user pin as seen at the port
    typedef struct packed {
        logic out;
        logic oe;
    } cfh_pin_s;

endpackage : cfh_pkg

// ### design/cfh_cycle_timer.sv
// Loadable down counter that flags expiry of a cycle count
module cfh_cycle_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [cfh_pkg::CFH_TIMER_W-1:0] count,
    // Status
    output logic expired
);
    import cfh_pkg::*;

    logic [CFH_TIMER_W-1:0] cnt;
    wire logic running = (cnt != '0);
    wire logic last = (cnt == CFH_TIMER_W'(1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
            expired <= 1'h0;
        end else if (start) begin
            cnt <= count;
            expired <= 1'h0;
        end else if (running) begin
            cnt <= cnt - CFH_TIMER_W'(1);
            expired <= last;
        end
    end

endmodule : cfh_cycle_timer

// ### design/cfh_od_driver.sv
// Registered driver for an open-drain pin that may become user I/O
module cfh_od_driver #(
    parameter logic RESET_DRIVE = 1'h0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic drive_low,
    input wire logic use_user,
    input wire cfh_pkg::cfh_pin_s user_pin,
    // Pin
    output cfh_pkg::cfh_pin_s pin
);
    import cfh_pkg::*;

    wire logic next_out = use_user ? user_pin.out : CFH_PIN_LOW;
    wire logic next_oe = use_user ? user_pin.oe : drive_low;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin.out <= CFH_PIN_LOW;
            pin.oe <= RESET_DRIVE;
        end else begin
            pin.out <= next_out;
            pin.oe <= next_oe;
        end
    end

endmodule : cfh_od_driver

// ### design/cfh_config_handshake.sv
// Status, load-complete and chain handshake of the configuration controller

//
// Contract
// - Drive status line low on configuration error
// - External status low during load enters error
// - Status line ignored once in user mode
// - Hold load-complete low before and during load
// - Release load-complete when image done, no error
// - Initialise only after load-complete seen high
// - Load-complete low in user mode is ignored
// - Chain enable low needed; high blocks configuration
// - Drive chain output low once configured
// - Chain output off makes pin user I/O
// - Memory select active in serial/parallel modes
// - Reload low discards, resets, tri-states; high reconfigures
// - Status driven low from power-up until reset interval
module cfh_config_handshake #(
    parameter int POR_TIME_NS = cfh_pkg::CFH_POR_TIME_NS_DEF,
    parameter int INIT_CYCLES = cfh_pkg::CFH_INIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Reload request and chain enable inputs
    input wire logic RELOAD_REQUEST_N,
    input wire logic CHAIN_ENABLE_IN_N,
    // Mode selection and options
    input wire logic ACTIVE_SERIAL_MODE,
    input wire logic ACTIVE_PARALLEL_MODE,
    input wire logic CHAIN_OUT_OPTION_EN,
    // Events from the data path
    input wire cfh_pkg::cfh_data_s DATA_EVENT,
    // Status line, open drain
    input wire logic STATUS_IN,
    output cfh_pkg::cfh_pin_s STATUS_PIN,
    // Load-complete line, open drain
    input wire logic LOAD_COMPLETE_IN,
    output cfh_pkg::cfh_pin_s LOAD_COMPLETE_PIN,
    // Chain enable output, open drain or user I/O
    input wire cfh_pkg::cfh_pin_s CHAIN_OUT_USER,
    output cfh_pkg::cfh_pin_s CHAIN_ENABLE_OUT,
    // Configuration memory select
    output logic PARALLEL_MEMORY_SELECT_N,
    // Controller state toward the core
    output logic CFG_ACCEPT,
    output logic IO_TRISTATE,
    output logic USER_MODE,
    output logic CFG_ERROR_STATE
);
    import cfh_pkg::*;

    // Derived cycle counts; the power-on interval rounds up
    localparam int POR_CYCLES_RAW =
        (POR_TIME_NS + CFH_CLK_PERIOD_NS - 1) / CFH_CLK_PERIOD_NS;
    localparam int POR_CYCLES = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
    localparam int INIT_CYCLES_MIN = (INIT_CYCLES < 1) ? 1 : INIT_CYCLES;
    localparam logic [CFH_TIMER_W-1:0] POR_COUNT = CFH_TIMER_W'(POR_CYCLES);
    localparam logic [CFH_TIMER_W-1:0] INIT_COUNT =
        CFH_TIMER_W'(INIT_CYCLES_MIN);

    // Controller state
    cfh_state_e state;
    cfh_state_e next_state;

    // Stays high after expiry until the timer is started again
    logic timer_expired;

    // Output levels while held in reset
    localparam logic ACCEPT_RST = 1'h0;
    localparam logic TRISTATE_RST = 1'h1;
    localparam logic USER_RST = 1'h0;
    localparam logic ERROR_RST = 1'h0;

    // Input decode
    wire logic reload_low = !RELOAD_REQUEST_N;
    wire logic chain_enabled = !CHAIN_ENABLE_IN_N;
    wire logic active_mode = ACTIVE_SERIAL_MODE | ACTIVE_PARALLEL_MODE;

    // Own drive must not be mistaken for an outside source
    wire logic status_ext_low = !STATUS_IN && !STATUS_PIN.oe;

    // State decode
    wire logic in_por = (state == CFH_ST_POR_ARM)
        || (state == CFH_ST_POR_WAIT);
    wire logic in_load = (state == CFH_ST_LOAD);
    wire logic in_release = (state == CFH_ST_RELEASE);
    wire logic in_init = (state == CFH_ST_INIT);

    // Phases in which the status line is watched
    wire logic watch_status = in_load || in_release || in_init;
    wire logic status_fault = watch_status && status_ext_low;

    // Data is taken only while the chain enable is held low
    wire logic accept_now = in_load && chain_enabled;

    // Data path events, one-cycle pulses
    wire logic data_error = DATA_EVENT.error;
    wire logic data_done = DATA_EVENT.image_done;
    wire logic load_fault = data_error || status_fault;
    wire logic load_done = accept_now && data_done;

    // Timer starts: power-on interval and initialisation cycle
    // Power-on count loads once, on the edge after reset
    wire logic start_por = (state == CFH_ST_POR_ARM);
    wire logic start_init = in_release && chain_enabled
        && LOAD_COMPLETE_IN && !status_ext_low;
    wire logic timer_start = start_por || start_init;
    wire logic [CFH_TIMER_W-1:0] timer_count =
        start_por ? POR_COUNT : INIT_COUNT;
    // A high chain enable pauses the end of initialisation
    wire logic init_done = timer_expired && chain_enabled;

    // Reload request overrides all but the power-on interval
    wire logic reload_take = reload_low && !in_por;

    // Next-state decode; pins move on the same edge as the state
    // Registered pins would otherwise lag the state flags a cycle
    wire logic next_por = (next_state == CFH_ST_POR_ARM)
        || (next_state == CFH_ST_POR_WAIT);
    wire logic next_load = (next_state == CFH_ST_LOAD);
    wire logic next_release = (next_state == CFH_ST_RELEASE);
    wire logic next_init = (next_state == CFH_ST_INIT);
    wire logic next_user = (next_state == CFH_ST_USER);
    wire logic next_error = (next_state == CFH_ST_ERROR);
    wire logic next_reload = (next_state == CFH_ST_RELOAD);

    // Pin drive decisions
    // Open drain: drive means pull the line low
    wire logic status_drive = next_por || next_error
        || next_reload;
    wire logic done_release = next_release || next_init
        || next_user;
    wire logic done_drive = !done_release;
    wire logic chain_drive = next_user;
    wire logic chain_user = next_user && !CHAIN_OUT_OPTION_EN;

    // Registered output values
    wire logic next_accept = next_load && chain_enabled;
    wire logic next_select_n = (next_accept && active_mode)
        ? CFH_SELECT_ON_N : CFH_SELECT_OFF_N;
    wire logic next_tristate = !next_user;

    always_comb begin
        next_state = state;
        case (state)
            CFH_ST_POR_ARM: begin
                next_state = CFH_ST_POR_WAIT;
            end
            CFH_ST_POR_WAIT: begin
                if (timer_expired) begin
                    next_state = CFH_ST_IDLE;
                end
            end
            CFH_ST_RELOAD: begin
                if (!reload_low) begin
                    next_state = CFH_ST_IDLE;
                end
            end
            CFH_ST_IDLE: begin
                if (chain_enabled) begin
                    next_state = CFH_ST_LOAD;
                end
            end
            CFH_ST_LOAD: begin
                if (load_fault) begin
                    next_state = CFH_ST_ERROR;
                end else if (load_done) begin
                    next_state = CFH_ST_RELEASE;
                end
            end
            CFH_ST_RELEASE: begin
                // Waits for load-complete high with chain enable low; outside status low enters error
                if (status_fault) begin
                    next_state = CFH_ST_ERROR;
                end else if (start_init) begin
                    next_state = CFH_ST_INIT;
                end
            end
            CFH_ST_INIT: begin
                if (status_fault) begin
                    next_state = CFH_ST_ERROR;
                end else if (init_done) begin
                    next_state = CFH_ST_USER;
                end
            end
            CFH_ST_USER: begin
                // Status and load-complete lines play no part here
                next_state = CFH_ST_USER;
            end
            CFH_ST_ERROR: begin
                // No data is taken; only a reload request leaves
                next_state = CFH_ST_ERROR;
            end
            default: begin
                next_state = CFH_ST_POR_ARM;
            end
        endcase
        // Last word goes to the reload request
        if (reload_take) begin
            next_state = CFH_ST_RELOAD;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state <= CFH_ST_POR_ARM;
        end else begin
            state <= next_state;
        end
    end

    // Memory select, active only while data is taken
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PARALLEL_MEMORY_SELECT_N <= CFH_SELECT_OFF_N;
        end else begin
            PARALLEL_MEMORY_SELECT_N <= next_select_n;
        end
    end

    // Data acceptance; never high in the error state
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CFG_ACCEPT <= ACCEPT_RST;
        end else begin
            CFG_ACCEPT <= next_accept;
        end
    end

    // User mode and I/O float
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            IO_TRISTATE <= TRISTATE_RST;
            USER_MODE <= USER_RST;
        end else begin
            IO_TRISTATE <= next_tristate;
            USER_MODE <= next_user;
        end
    end

    // Error state flag
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CFG_ERROR_STATE <= ERROR_RST;
        end else begin
            CFG_ERROR_STATE <= next_error;
        end
    end

    // Shared timer for power-on interval and initialisation
    cfh_cycle_timer u_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .start(timer_start),
        .count(timer_count),
        .expired(timer_expired)
    );

    // Status line, driven low from reset until the power-on interval ends
    cfh_od_driver #(
        .RESET_DRIVE(CFH_DRIVE)
    ) u_status (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .drive_low(status_drive),
        .use_user(1'h0),
        .user_pin('0),
        .pin(STATUS_PIN)
    );

    // Load-complete line, low until the image is in
    cfh_od_driver #(
        .RESET_DRIVE(CFH_DRIVE)
    ) u_load_complete (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .drive_low(done_drive),
        .use_user(1'h0),
        .user_pin('0),
        .pin(LOAD_COMPLETE_PIN)
    );

    // Chain enable output or user I/O
    cfh_od_driver #(
        .RESET_DRIVE(CFH_RELEASE)
    ) u_chain_out (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .drive_low(chain_drive),
        .use_user(chain_user),
        .user_pin(CHAIN_OUT_USER),
        .pin(CHAIN_ENABLE_OUT)
    );

endmodule : cfh_config_handshake

// ### testbench/cfh_handshake_monitor.sv
// Port checker for the configuration handshake
module cfh_handshake_monitor #(
    parameter int POR_TIME_NS = 200,
    parameter int INIT_CYCLES = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic RELOAD_REQUEST_N,
    input wire logic ACTIVE_SERIAL_MODE,
    input wire logic ACTIVE_PARALLEL_MODE,
    input wire logic CHAIN_OUT_OPTION_EN,
    input wire logic STATUS_IN,
    input wire cfh_pkg::cfh_pin_s STATUS_PIN,
    input wire logic LOAD_COMPLETE_IN,
    input wire cfh_pkg::cfh_pin_s LOAD_COMPLETE_PIN,
    input wire cfh_pkg::cfh_pin_s CHAIN_ENABLE_OUT,
    input wire logic PARALLEL_MEMORY_SELECT_N,
    input wire logic CFG_ACCEPT,
    input wire logic IO_TRISTATE,
    input wire logic USER_MODE,
    input wire logic CFG_ERROR_STATE
);
    timeunit 1ns;
    timeprecision 1ns;
    import cfh_pkg::*;
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    a_error_status: assert property (
        $rose(CFG_ERROR_STATE) |-> STATUS_PIN.oe)
        else $error("status not pulled in error");
    a_ext_status: assert property (
        CFG_ACCEPT && !STATUS_IN && !STATUS_PIN.oe && RELOAD_REQUEST_N
        && $past(RELOAD_REQUEST_N) |-> ##[1:2] CFG_ERROR_STATE)
        else $error("outside status low missed");
    a_error_hold: assert property (
        CFG_ERROR_STATE && RELOAD_REQUEST_N && $past(RELOAD_REQUEST_N)
        |=> CFG_ERROR_STATE)
        else $error("error state left");
    a_user_keep: assert property (
        USER_MODE && RELOAD_REQUEST_N && $past(RELOAD_REQUEST_N)
        |=> USER_MODE)
        else $error("user mode left");
    a_lc_load: assert property (
        CFG_ACCEPT |-> LOAD_COMPLETE_PIN.oe)
        else $error("load-complete released in load");
    a_init_gate: assert property (
        $rose(USER_MODE) |-> LOAD_COMPLETE_IN && !LOAD_COMPLETE_PIN.oe)
        else $error("user mode without line high");
    a_chain_done: assert property (
        $rose(USER_MODE) && CHAIN_OUT_OPTION_EN
        |-> CHAIN_ENABLE_OUT.oe && !CHAIN_ENABLE_OUT.out)
        else $error("chain output not low");
    a_select_gate: assert property (
        !PARALLEL_MEMORY_SELECT_N
        |-> CFG_ACCEPT && (ACTIVE_SERIAL_MODE || ACTIVE_PARALLEL_MODE))
        else $error("select outside load");
    a_reload_float: assert property (
        USER_MODE && !RELOAD_REQUEST_N ##1 !RELOAD_REQUEST_N
        |=> IO_TRISTATE && !USER_MODE && STATUS_PIN.oe)
        else $error("reload not honoured");
    c_user: cover property ($rose(USER_MODE));
    c_error: cover property ($rose(CFG_ERROR_STATE));
    c_select: cover property ($fell(PARALLEL_MEMORY_SELECT_N));
endmodule : cfh_handshake_monitor

bind cfh_config_handshake cfh_handshake_monitor #(
    .POR_TIME_NS(POR_TIME_NS),
    .INIT_CYCLES(INIT_CYCLES)
) cfh_handshake_monitor_i (
    .SYS_CLK, .RST_N, .RELOAD_REQUEST_N, .ACTIVE_SERIAL_MODE,
    .ACTIVE_PARALLEL_MODE, .CHAIN_OUT_OPTION_EN, .STATUS_IN, .STATUS_PIN,
    .LOAD_COMPLETE_IN, .LOAD_COMPLETE_PIN, .CHAIN_ENABLE_OUT,
    .PARALLEL_MEMORY_SELECT_N, .CFG_ACCEPT, .IO_TRISTATE, .USER_MODE,
    .CFG_ERROR_STATE
);

// ### testbench/cfh_host_model.sv
// Configuration memory model and pull-ups on the shared lines
module cfh_host_model (
    input wire logic clk,
    input wire logic accept,
    input wire logic slow,
    input wire logic inject_err,
    input wire logic pull_status,
    input wire logic pull_lc,
    input wire cfh_pkg::cfh_pin_s status_pin,
    input wire cfh_pkg::cfh_pin_s lc_pin,
    output logic status_wire,
    output logic lc_wire,
    output cfh_pkg::cfh_data_s event_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import cfh_pkg::*;
    int cnt = 0;
    logic status_q = 1'h1;
    // Open-drain wires with pull-up
    assign status_wire = !(status_pin.oe || pull_status);
    assign lc_wire = !(lc_pin.oe || pull_lc);
    always @(posedge clk) begin
        status_q <= status_wire;
        cnt <= accept ? cnt + 1 : 0;
        event_out.error <= inject_err && accept;
        // Short or long image; image done also pulses when status is pulled low
        event_out.image_done <= (accept && cnt == (slow ? 12 : 3))
            || (status_q && !status_wire);
    end
endmodule : cfh_host_model

// ### testbench/tb_top.sv
// Self-checking bench for the configuration handshake
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cfh_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic reload_n = 1'h1;
    logic chain_in_n = 1'h1;
    logic ser = 1'h0;
    logic par = 1'h0;
    logic opt = 1'h1;
    logic slow = 1'h0;
    logic inj = 1'h0;
    logic p_st = 1'h0;
    logic p_lc = 1'h0;
    cfh_pin_s usr = 2'h3;
    logic st_w, lc_w, sel_n, acc, tri_io, user, err;
    cfh_data_s ev;
    cfh_pin_s st_pin, lc_pin, ch_out;
    int bad_count = 0;
    int checks_done = 0;
    wire logic [4:0] mon = {lc_pin.oe, st_pin.oe, err, user, acc};
    cfh_config_handshake #(.POR_TIME_NS(200), .INIT_CYCLES(4))
    cfh_config_handshake_i (
        .SYS_CLK(clk), .RST_N(rst_n), .RELOAD_REQUEST_N(reload_n),
        .CHAIN_ENABLE_IN_N(chain_in_n), .ACTIVE_SERIAL_MODE(ser),
        .ACTIVE_PARALLEL_MODE(par), .CHAIN_OUT_OPTION_EN(opt),
        .DATA_EVENT(ev), .STATUS_IN(st_w), .STATUS_PIN(st_pin),
        .LOAD_COMPLETE_IN(lc_w), .LOAD_COMPLETE_PIN(lc_pin),
        .CHAIN_OUT_USER(usr), .CHAIN_ENABLE_OUT(ch_out),
        .PARALLEL_MEMORY_SELECT_N(sel_n), .CFG_ACCEPT(acc),
        .IO_TRISTATE(tri_io), .USER_MODE(user), .CFG_ERROR_STATE(err));
    cfh_host_model cfh_host_model_i (
        .clk(clk), .accept(acc), .slow(slow), .inject_err(inj),
        .pull_status(p_st), .pull_lc(p_lc), .status_pin(st_pin),
        .lc_pin(lc_pin), .status_wire(st_w), .lc_wire(lc_w),
        .event_out(ev));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        #1;
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int w, input logic v, input int lim,
                      output int n);
        n = 0;
        while (mon[w] !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                bad_count++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, mon, v);
                summarize();
            end
        end
    endtask : wt
    task automatic t_chain();
        int n;
        chk({tri_io, user, st_pin.oe, lc_pin.oe}, 4'hB);
        wt(3, 1'h0, 30, n);
        chk(n >= 10, 4'h1);
        repeat (8) begin
            @(posedge clk);
            chk({acc, lc_pin.oe}, 4'h1);
        end
        @(posedge clk);
        chain_in_n <= 1'h0;
        $display("test power-up and chain done");
    endtask : t_chain
    task automatic t_config(input logic s);
        int n;
        @(posedge clk);
        slow <= s;
        p_lc <= 1'h1;
        wt(0, 1'h1, 6, n);
        chk({lc_pin.oe, sel_n}, {1'h1, !(ser || par)});
        wt(4, 1'h0, 20, n);
        chk({acc, sel_n}, 4'h1);
        repeat (6) begin
            @(posedge clk);
            chk(user, 4'h0);
        end
        @(posedge clk);
        p_lc <= 1'h0;
        wt(1, 1'h1, 10, n);
        chk(ch_out, opt ? 2'h1 : usr);
        chk({tri_io, err}, 4'h0);
        $display("test configuration done");
    endtask : t_config
    task automatic t_user();
        @(posedge clk);
        p_st <= 1'h1;
        p_lc <= 1'h1;
        repeat (6) begin
            @(posedge clk);
            chk({user, err, acc}, 4'h4);
        end
        @(posedge clk);
        p_st <= 1'h0;
        p_lc <= 1'h0;
        chk({user, tri_io}, 4'h2);
        $display("test user mode done");
    endtask : t_user
    task automatic t_reload(input logic a, input logic b, input logic o);
        int n;
        @(posedge clk);
        reload_n <= 1'h0;
        ser <= a;
        par <= b;
        opt <= o;
        repeat (3) @(posedge clk);
        chk({tri_io, user, st_pin.oe, lc_pin.oe}, 4'hB);
        @(posedge clk);
        reload_n <= 1'h1;
        wt(3, 1'h0, 5, n);
        $display("test reload done");
    endtask : t_reload
    task automatic t_error(input logic ext);
        int n;
        @(posedge clk);
        slow <= 1'h1;
        wt(0, 1'h1, 6, n);
        @(posedge clk);
        inj <= !ext;
        p_st <= ext;
        @(posedge clk);
        inj <= 1'h0;
        p_st <= 1'h0;
        wt(2, 1'h1, 5, n);
        chk({st_pin.oe, lc_pin.oe, acc}, 4'h6);
        repeat (20) begin
            @(posedge clk);
            chk({err, acc, user}, 4'h4);
        end
        $display("test error done");
    endtask : t_error
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_chain();
        t_config(1'h0);
        t_user();
        t_reload(1'h1, 1'h0, 1'h0);
        t_config(1'h1);
        t_reload(1'h0, 1'h1, 1'h1);
        t_error(1'h0);
        t_reload(1'h1, 1'h0, 1'h1);
        t_error(1'h1);
        t_reload(1'h0, 1'h0, 1'h1);
        t_config(1'h0);
        summarize();
    end
endmodule : tb_top
